// *** pbs_sram_device.sv ***
// Device end: pipelined late-write burst SRAM seen at its pins.
`timescale 1ns/100ps
module pbs_sram_device (
  input logic sys_clk,
  input logic resetn,
  pbs_link_if.dev link,
  input logic polaritySelA,
  input logic polaritySelB
);
  localparam int AW = pbs_pkg::ADDR_W;
  localparam int DW = pbs_pkg::DATA_W;
  localparam int BW = pbs_pkg::BURST_W;
  localparam int UW = pbs_pkg::UP_W;
  localparam int NL = pbs_pkg::LANES;
  localparam int LW = pbs_pkg::LANE_W;

  logic [2:0] linkSync_reg;
  logic [1:0] strapMeta_reg;
  logic [1:0] strap_reg;
  pbs_pkg::pbs_op_t op_reg;
  logic [UW-1:0] upper_reg;
  logic [BW-1:0] base_reg;
  logic [BW-1:0] count_reg;
  logic rdPend_reg;
  logic [AW-1:0] rdAddr_reg;
  logic echoPend_reg;
  logic wr1Valid_reg;
  logic [AW-1:0] wr1Addr_reg;
  logic [NL-1:0] wr1Mask_reg;
  logic wr2Valid_reg;
  logic [AW-1:0] wr2Addr_reg;
  logic [NL-1:0] wr2Mask_reg;
  logic [DW-1:0] dqOut_reg;
  logic dqOe_reg;
  logic echoOe_reg;
  logic echoTrue_reg;
  logic echoInv_reg;
  logic [DW-1:0] mem [0:pbs_pkg::MEM_WORDS-1];

  // Rising edge of the link clock, seen after the two-stage synchroniser.
  wire tick;
  wire enableA;
  wire enableB;
  wire combinedEnable;
  wire loadCycle;
  wire linearOrder;
  wire anyByte;
  wire [BW-1:0] countNext;
  wire [BW-1:0] baseNext;
  wire [UW-1:0] upperNext;
  wire [BW-1:0] lowAddr;
  wire [AW-1:0] curAddr;
  pbs_pkg::pbs_op_t loadOp;
  pbs_pkg::pbs_op_t curOp;

  assign tick = linkSync_reg[1] & ~linkSync_reg[2];
  assign enableA = link.progEnableA == strap_reg[1];
  assign enableB = link.progEnableB == strap_reg[0];
  assign combinedEnable = enableA & enableB;
  assign loadCycle = ~link.advanceLoad;
  assign linearOrder = ~link.burstOrderSelN;
  assign anyByte = ~&link.byteWriteN;

  // A load decodes a new operation; a continue repeats the last one.
  assign loadOp = !combinedEnable ? pbs_pkg::OP_BANK_DES :
                  link.primaryEnableN ? pbs_pkg::OP_DES :
                  !link.writeSelN ? pbs_pkg::OP_WRITE :
                  pbs_pkg::OP_READ;
  assign curOp = loadCycle ? loadOp : op_reg;

  // The burst count wraps modulo four back to the start address.
  assign countNext = loadCycle ? pbs_pkg::CNT_ZERO :
                     count_reg + pbs_pkg::CNT_ONE;
  assign baseNext = loadCycle ? link.address[BW-1:0] : base_reg;
  assign upperNext = loadCycle ? link.address[AW-1:BW] : upper_reg;
  assign lowAddr = pbs_pkg::burst_low(baseNext, countNext,
                                      linearOrder);
  assign curAddr = {upperNext, lowAddr};

  logic readNow;
  logic writeNow;
  logic bankOn;

  always_comb begin
    readNow = 1'b0;
    writeNow = 1'b0;
    bankOn = 1'b1;
    case (curOp)
      pbs_pkg::OP_BANK_DES: begin
        bankOn = 1'b0;
      end
      pbs_pkg::OP_DES: begin
        bankOn = 1'b1;
      end
      pbs_pkg::OP_WRITE: begin
        writeNow = anyByte;
      end
      pbs_pkg::OP_READ: begin
        readNow = 1'b1;
      end
      default: begin
        bankOn = 1'b0;
      end
    endcase
  end

  // Link clock synchroniser; only the later stages feed the edge finder.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      linkSync_reg <= 3'h0;
    end else begin
      linkSync_reg <= {linkSync_reg[1:0], link.linkClk};
    end
  end

  // Polarity straps are caught through two flip-flops.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      strapMeta_reg <= 2'h0;
      strap_reg <= 2'h0;
    end else begin
      strapMeta_reg <= {polaritySelA, polaritySelB};
      strap_reg <= strapMeta_reg;
    end
  end

  // Operation state and burst address register.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      op_reg <= pbs_pkg::OP_BANK_DES;
      upper_reg <= '0;
      base_reg <= pbs_pkg::CNT_ZERO;
      count_reg <= pbs_pkg::CNT_ZERO;
    end else if (tick) begin
      op_reg <= curOp;
      upper_reg <= upperNext;
      base_reg <= baseNext;
      count_reg <= countNext;
    end
  end

  // Read pipeline: the addressed word leaves at the following edge.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdPend_reg <= 1'b0;
      rdAddr_reg <= '0;
      echoPend_reg <= 1'b0;
    end else if (tick) begin
      rdPend_reg <= readNow;
      rdAddr_reg <= curAddr;
      echoPend_reg <= bankOn;
    end
  end

  // Output stage for data and echo drivers, both one cycle late.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dqOut_reg <= '0;
      dqOe_reg <= 1'b0;
      echoOe_reg <= 1'b0;
    end else if (tick) begin
      if (rdPend_reg) begin
        dqOut_reg <= mem[rdAddr_reg];
      end
      dqOe_reg <= rdPend_reg;
      echoOe_reg <= echoPend_reg;
    end
  end

  // Echo clocks are delayed true and inverted copies of the link clock.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      echoTrue_reg <= 1'b0;
      echoInv_reg <= 1'b1;
    end else begin
      echoTrue_reg <= linkSync_reg[1];
      echoInv_reg <= ~linkSync_reg[1];
    end
  end

  // Write pipeline: data is taken at the third edge of the command.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr1Valid_reg <= 1'b0;
      wr1Addr_reg <= '0;
      wr1Mask_reg <= '1;
      wr2Valid_reg <= 1'b0;
      wr2Addr_reg <= '0;
      wr2Mask_reg <= '1;
    end else if (tick) begin
      wr1Valid_reg <= writeNow;
      wr1Addr_reg <= curAddr;
      wr1Mask_reg <= link.byteWriteN;
      wr2Valid_reg <= wr1Valid_reg;
      wr2Addr_reg <= wr1Addr_reg;
      wr2Mask_reg <= wr1Mask_reg;
    end
  end

  // Array store, one lane per byte strobe; the array has no reset.
  always_ff @(posedge sys_clk) begin
    if (tick && wr2Valid_reg) begin
      for (int i = 0; i < NL; i++) begin
        if (!wr2Mask_reg[i]) begin
          mem[wr2Addr_reg][i*LW +: LW] <= link.dqIn[i*LW +: LW];
        end
      end
    end
  end

  assign link.devDqOut = dqOut_reg;
  assign link.devDqOe = dqOe_reg;
  assign link.echoClkTrue1 = echoTrue_reg;
  assign link.echoClkTrue2 = echoTrue_reg;
  assign link.echoClkInv1 = echoInv_reg;
  assign link.echoClkInv2 = echoInv_reg;
  assign link.echoOe = echoOe_reg;
endmodule : pbs_sram_device

// *** pbs_pkg.sv ***
// Constants, types and helpers shared by both ends of the burst SRAM port.
// Functional notes
// - Load, all enables true, write high: read.
// - Read data driven at the following edge.
// - Enables true with write select low: write.
// - Controller supplies write data at third edge.
// - Advance high continues using counter address.
// - Advance low loads the external start address.
// - Burst order pin high interleaved, low linear.
// - Interleaved order XORs start with count.
// - Linear order adds count modulo four.
// - Fourth continue wraps back to start address.
// - Two true, two inverted echo clocks.
// - Programmable enable deselect stops echo drivers.
// - Echo disable has the data output latency.
// - Primary enable deselect keeps echo clocks running.
// - Select pin level sets each enable polarity.
// - Two address lines pick one of four banks.
// - Pause with deselect at read bank switch.
// - Combined enable true when both match selects.
// - Low byte strobes store lanes; none aborts.
// - Data pins float a cycle after non-read.
// - Three continues give four words per address.
package pbs_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 72;
  localparam int LANES = 8;
  localparam int LANE_W = 9;
  localparam int BURST_W = 2;
  localparam int UP_W = ADDR_W - BURST_W;
  localparam int MEM_WORDS = 1 << ADDR_W;
  localparam int BANK_W = 2;
  localparam int SYS_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_DIV = LINK_PERIOD_NS / SYS_PERIOD_NS;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(LINK_DIV / 2);
  localparam logic [DIV_W-1:0] DIV_ISSUE = DIV_W'(LINK_DIV / 2 - 1);
  localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
  localparam logic [BURST_W-1:0] CNT_ONE = 2'h1;
  localparam logic [BURST_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  localparam logic [1:0] BUF_ONE = 2'h1;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic [3:0] {
    OP_BANK_DES = 4'h1,
    OP_DES = 4'h2,
    OP_WRITE = 4'h4,
    OP_READ = 4'h8
  } pbs_op_t;

  typedef enum logic [1:0] {
    CMD_DESELECT = 2'h0,
    CMD_READ = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_CONTINUE = 2'h3
  } pbs_cmd_t;

  function automatic logic [BURST_W-1:0] burst_low(
    input logic [BURST_W-1:0] base,
    input logic [BURST_W-1:0] cnt,
    input logic linear
  );
    return linear ? base + cnt : base ^ cnt;
  endfunction : burst_low
endpackage : pbs_pkg

// *** pbs_link_if.sv ***
// Pin bundle joining the SRAM controller end to the SRAM device end.
`timescale 1ns/100ps
interface pbs_link_if;
  logic linkClk;
  logic primaryEnableN;
  logic progEnableA;
  logic progEnableB;
  logic advanceLoad;
  logic writeSelN;
  logic [pbs_pkg::ADDR_W-1:0] address;
  logic [pbs_pkg::LANES-1:0] byteWriteN;
  logic burstOrderSelN;
  logic [pbs_pkg::DATA_W-1:0] ctlDqOut;
  logic ctlDqOe;
  logic [pbs_pkg::DATA_W-1:0] devDqOut;
  logic devDqOe;
  logic echoClkTrue1;
  logic echoClkTrue2;
  logic echoClkInv1;
  logic echoClkInv2;
  logic echoOe;
  wire [pbs_pkg::DATA_W-1:0] dqIn;

  // Resolves the shared data pins; an undriven bus reads as zero.
  assign dqIn = devDqOe ? devDqOut : (ctlDqOe ? ctlDqOut : '0);

  modport ctl (
    output linkClk, primaryEnableN, progEnableA, progEnableB,
    output advanceLoad, writeSelN, address, byteWriteN, burstOrderSelN,
    output ctlDqOut, ctlDqOe,
    input dqIn
  );

  modport dev (
    input linkClk, primaryEnableN, progEnableA, progEnableB,
    input advanceLoad, writeSelN, address, byteWriteN, burstOrderSelN,
    output devDqOut, devDqOe,
    output echoClkTrue1, echoClkTrue2, echoClkInv1, echoClkInv2, echoOe,
    input dqIn
  );
endinterface : pbs_link_if

// *** pbs_sram_ctl.sv ***
// Controller end: drives the SRAM pins and buffers returned read words.
`timescale 1ns/100ps
module pbs_sram_ctl (
  input logic sys_clk,
  input logic resetn,
  pbs_link_if.ctl link,
  input logic orderLinear,
  input logic cmdValid,
  output logic cmdReady,
  input pbs_pkg::pbs_cmd_t cmdKind,
  input logic [pbs_pkg::BANK_W-1:0] cmdBank,
  input logic [pbs_pkg::ADDR_W-1:0] cmdAddr,
  input logic [pbs_pkg::LANES-1:0] cmdByteWriteN,
  input logic [pbs_pkg::DATA_W-1:0] cmdWdata,
  output logic rdValid,
  input logic rdReady,
  output logic [pbs_pkg::DATA_W-1:0] rdData
);
  localparam int DW = pbs_pkg::DATA_W;

  logic [pbs_pkg::DIV_W-1:0] div_reg;
  logic linkClk_reg;
  logic peN_reg;
  logic [pbs_pkg::BANK_W-1:0] bank_reg;
  logic adv_reg;
  logic wsel_reg;
  logic [pbs_pkg::ADDR_W-1:0] addr_reg;
  logic [pbs_pkg::LANES-1:0] bwN_reg;
  logic ordN_reg;
  logic pendRead_reg;
  logic pendWrite_reg;
  logic [DW-1:0] pendData_reg;
  logic lastRead_reg;
  logic lastWrite_reg;
  logic hold_reg;
  logic s1_reg;
  logic s2_reg;
  logic w1Valid_reg;
  logic [DW-1:0] w1Data_reg;
  logic w2Valid_reg;
  logic [DW-1:0] w2Data_reg;
  logic [DW-1:0] dqOut_reg;
  logic dqOe_reg;
  logic cmdReady_reg;
  logic [DW-1:0] head_reg;
  logic [DW-1:0] spare_reg;
  logic [1:0] cnt_reg;
  logic rdValid_reg;

  wire riseNow = div_reg == pbs_pkg::DIV_LAST;
  wire fallNow = div_reg == pbs_pkg::DIV_ISSUE;
  wire [pbs_pkg::DIV_W-1:0] divNext = riseNow ? pbs_pkg::DIV_ZERO :
                                      div_reg + pbs_pkg::DIV_ONE;
  wire take = cmdValid & cmdReady_reg;
  wire kRead = cmdKind == pbs_pkg::CMD_READ;
  wire kWrite = cmdKind == pbs_pkg::CMD_WRITE;
  wire kCont = cmdKind == pbs_pkg::CMD_CONTINUE;
  wire bankSwitch = kRead & lastRead_reg & (cmdBank != bank_reg);
  wire holdNext = take & bankSwitch;
  wire pendReadNext = hold_reg | (take & ~bankSwitch &
                      (kRead | (kCont & lastRead_reg)));
  wire pendWriteNext = take & (kWrite | (kCont & lastWrite_reg));
  wire peNNext = hold_reg ? 1'b0 :
                 ~(take & (kRead | kWrite) & ~bankSwitch);
  wire advNext = take & kCont;
  wire lastReadNext = (take & kCont) ? lastRead_reg : pendReadNext;
  wire lastWriteNext = (take & kCont) ? lastWrite_reg : (take & kWrite);
  wire room = (cnt_reg == pbs_pkg::BUF_EMPTY && !(s1_reg && s2_reg)) ||
              (cnt_reg == pbs_pkg::BUF_ONE && !s1_reg && !s2_reg);
  wire push = riseNow & s2_reg;
  wire pop = rdValid_reg & rdReady;
  wire [1:0] cntNext = cnt_reg + {1'b0, push} - {1'b0, pop};
  wire toHead = push && (cnt_reg == pbs_pkg::BUF_EMPTY ||
                (cnt_reg == pbs_pkg::BUF_ONE && pop));
  wire toSpare = push && !toHead;

  // Link clock divider; the clock rises after the last count.
  // Reset parks the count there so the first high phase is full length.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= pbs_pkg::DIV_LAST;
      linkClk_reg <= 1'b0;
      ordN_reg <= 1'b1;
      cmdReady_reg <= 1'b0;
    end else begin
      div_reg <= divNext;
      linkClk_reg <= divNext < pbs_pkg::DIV_HALF;
      ordN_reg <= ~orderLinear;
      cmdReady_reg <= (divNext == pbs_pkg::DIV_ISSUE) & room & ~hold_reg;
    end
  end

  // Command pins change only while the link clock is low.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      peN_reg <= 1'b1;
      adv_reg <= 1'b0;
      wsel_reg <= 1'b1;
      pendRead_reg <= 1'b0;
      pendWrite_reg <= 1'b0;
      lastRead_reg <= 1'b0;
      lastWrite_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else if (fallNow) begin
      peN_reg <= peNNext;
      adv_reg <= advNext;
      wsel_reg <= ~(take & kWrite);
      pendRead_reg <= pendReadNext;
      pendWrite_reg <= pendWriteNext;
      lastRead_reg <= lastReadNext;
      lastWrite_reg <= lastWriteNext;
      hold_reg <= holdNext;
    end
  end

  // Address, bank and strobes of an accepted command.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bank_reg <= '0;
      addr_reg <= '0;
      bwN_reg <= '1;
      pendData_reg <= '0;
    end else if (fallNow && take) begin
      bank_reg <= cmdBank;
      addr_reg <= cmdAddr;
      bwN_reg <= cmdByteWriteN;
      pendData_reg <= cmdWdata;
    end
  end

  // Read and write pipelines follow the device edges.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      w1Valid_reg <= 1'b0;
      w1Data_reg <= '0;
      w2Valid_reg <= 1'b0;
      w2Data_reg <= '0;
    end else if (riseNow) begin
      s1_reg <= pendRead_reg;
      s2_reg <= s1_reg;
      w1Valid_reg <= pendWrite_reg;
      w1Data_reg <= pendData_reg;
      w2Valid_reg <= w1Valid_reg;
      w2Data_reg <= w1Data_reg;
    end
  end

  // Write data stands for one link period ending at the third edge.
  // Releasing there keeps the pins free for read data that follows.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dqOut_reg <= '0;
      dqOe_reg <= 1'b0;
    end else if (divNext == pbs_pkg::DIV_ISSUE) begin
      dqOut_reg <= w2Data_reg;
      dqOe_reg <= w2Valid_reg;
    end
  end

  // Two-entry read buffer; reads are not issued without room.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      head_reg <= '0;
      spare_reg <= '0;
      cnt_reg <= pbs_pkg::BUF_EMPTY;
      rdValid_reg <= 1'b0;
    end else begin
      if (toHead) begin
        head_reg <= link.dqIn;
      end else if (pop && cnt_reg == pbs_pkg::BUF_FULL) begin
        head_reg <= spare_reg;
      end
      if (toSpare) begin
        spare_reg <= link.dqIn;
      end
      cnt_reg <= cntNext;
      rdValid_reg <= cntNext != pbs_pkg::BUF_EMPTY;
    end
  end

  assign link.linkClk = linkClk_reg;
  assign link.primaryEnableN = peN_reg;
  assign link.progEnableA = bank_reg[1];
  assign link.progEnableB = bank_reg[0];
  assign link.advanceLoad = adv_reg;
  assign link.writeSelN = wsel_reg;
  assign link.address = addr_reg;
  assign link.byteWriteN = bwN_reg;
  assign link.burstOrderSelN = ordN_reg;
  assign link.ctlDqOut = dqOut_reg;
  assign link.ctlDqOe = dqOe_reg;
  assign cmdReady = cmdReady_reg;
  assign rdValid = rdValid_reg;
  assign rdData = head_reg;
endmodule : pbs_sram_ctl

// *** pbs_link_assertions.sv ***
// Checker of the pin relations between the two ends of the SRAM port.
`timescale 1ns/100ps
module pbs_link_assertions (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic polaritySelA,
  input wire logic polaritySelB,
  input wire logic linkClk,
  input wire logic primaryEnableN,
  input wire logic progEnableA,
  input wire logic progEnableB,
  input wire logic advanceLoad,
  input wire logic writeSelN,
  input wire logic [pbs_pkg::ADDR_W-1:0] address,
  input wire logic [pbs_pkg::LANES-1:0] byteWriteN,
  input wire logic ctlDqOe,
  input wire logic devDqOe,
  input wire logic echoClkTrue1,
  input wire logic echoClkTrue2,
  input wire logic echoClkInv1,
  input wire logic echoClkInv2,
  input wire logic echoOe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  wire bankTrue;
  wire selLoad;
  wire rdLoad;
  wire wrLoad;
  wire dqOffCmd;
  assign bankTrue = (progEnableA == polaritySelA) &&
    (progEnableB == polaritySelB);
  assign selLoad = bankTrue && !primaryEnableN;
  assign rdLoad = selLoad && writeSelN;
  assign wrLoad = selLoad && !writeSelN && (byteWriteN != 8'hff);
  assign dqOffCmd = !bankTrue || primaryEnableN || !writeSelN;

  // A load command as the device sees it at a link clock rise.
  sequence cmdEdge;
    $rose(linkClk) && !advanceLoad;
  endsequence
  // High four cycles, low four cycles.
  sequence linkPeriod;
    linkClk[*3] ##1 !linkClk[*4] ##1 linkClk;
  endsequence

  link_period_a: assert property ($rose(linkClk) |=> linkPeriod)
    else $error("link clock period wrong");
  pins_stable_a: assert property ($rose(linkClk) |-> ##1
    ($stable(address)
    && $stable(writeSelN) && $stable(advanceLoad)
    && $stable(primaryEnableN))[*3]) else $error("pins moved near rise");
  read_latency_a: assert property (cmdEdge ##0 rdLoad
    |-> ##[9:13] devDqOe)
    else $error("read data not driven at next edge");
  write_data_a: assert property (cmdEdge ##0 wrLoad
    |-> ##15 ctlDqOe[*4])
    else $error("write data not at third edge");
  dq_float_a: assert property (cmdEdge ##0 dqOffCmd
    |-> ##[1:14] !devDqOe)
    else $error("data pins not released");
  bank_echo_off_a: assert property (cmdEdge ##0 !bankTrue
    |-> ##[1:14] !echoOe) else $error("echo kept on bank deselect");
  echo_kept_a: assert property (cmdEdge ##0 bankTrue
    |-> ##[1:14] echoOe) else $error("echo off while bank selected");
  echo_tracks_a: assert property (devDqOe |-> echoOe)
    else $error("data driven without echo");
  echo_phase_a: assert property (echoOe
    |-> echoClkInv1 == !echoClkTrue1
    && echoClkTrue2 == echoClkTrue1 && echoClkInv2 == echoClkInv1)
    else $error("echo pair mismatch");
  dq_contention_a: assert property (!(devDqOe && ctlDqOe))
    else $error("both ends drive data");
endmodule : pbs_link_assertions

// *** pipelined_burst_sram_port_test.sv ***
// Testbench joining controller and device ends of the SRAM port.
`timescale 1ns/100ps
module pipelined_burst_sram_port_test;
  localparam logic [1:0] BK = 2'h2;
  logic sys_clk;
  logic resetn;
  logic polaritySelA;
  logic polaritySelB;
  logic orderLinear;
  logic cmdValid;
  logic cmdReady;
  pbs_pkg::pbs_cmd_t cmdKind;
  logic [1:0] cmdBank;
  logic [17:0] cmdAddr;
  logic [7:0] cmdByteWriteN;
  logic [71:0] cmdWdata;
  logic rdValid;
  logic rdReady;
  logic [71:0] rdData;
  logic [71:0] mem [int];
  int n_fail;
  int comparisons;

  pbs_link_if link ();
  pbs_sram_device pbs_sram_device_i (.sys_clk(sys_clk), .resetn(resetn),
    .link(link), .polaritySelA(polaritySelA), .polaritySelB(polaritySelB));
  pbs_sram_ctl pbs_sram_ctl_i (.sys_clk(sys_clk), .resetn(resetn),
    .link(link), .orderLinear(orderLinear), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdBank(cmdBank),
    .cmdAddr(cmdAddr), .cmdByteWriteN(cmdByteWriteN), .cmdWdata(cmdWdata),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
  pbs_link_assertions pbs_link_assertions_i (.sys_clk(sys_clk),
    .resetn(resetn), .polaritySelA(polaritySelA),
    .polaritySelB(polaritySelB), .linkClk(link.linkClk),
    .primaryEnableN(link.primaryEnableN), .progEnableA(link.progEnableA),
    .progEnableB(link.progEnableB), .advanceLoad(link.advanceLoad),
    .writeSelN(link.writeSelN), .address(link.address),
    .byteWriteN(link.byteWriteN), .ctlDqOe(link.ctlDqOe),
    .devDqOe(link.devDqOe), .echoClkTrue1(link.echoClkTrue1),
    .echoClkTrue2(link.echoClkTrue2), .echoClkInv1(link.echoClkInv1),
    .echoClkInv2(link.echoClkInv2), .echoOe(link.echoOe));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    #500000;
    n_fail++;
    test_done();
  end

  function automatic logic [71:0] merge(input logic [71:0] o,
    input logic [71:0] w, input logic [7:0] bw);
    merge = o;
    for (int i = 0; i < 8; i++) if (!bw[i]) merge[9*i +: 9] = w[9*i +: 9];
  endfunction : merge

  task automatic chk(input string what, input logic [71:0] e,
    input logic [71:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  task automatic rst(input logic lin);
    resetn = 1'b0;
    orderLinear = lin;
    repeat (6) @(posedge sys_clk);
    #2 resetn = 1'b1;
  endtask : rst

  task automatic send(input pbs_pkg::pbs_cmd_t k, input logic [17:0] a,
    input logic [7:0] bw, input logic [71:0] d, input logic [1:0] b);
    int n;
    @(posedge sys_clk);
    #2;
    cmdKind = k;
    cmdAddr = a;
    cmdByteWriteN = bw;
    cmdWdata = d;
    cmdBank = b;
    cmdValid = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 200);
    if (n >= 200) chk("cmdReady", 72'h1, 72'(cmdReady));
    #2 cmdValid = 1'b0;
  endtask : send

  task automatic getRd(input logic [71:0] e);
    int n;
    @(posedge sys_clk);
    #2 rdReady = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rdValid !== 1'b1 && n < 100);
    if (n >= 100) chk("rdValid", 72'h1, 72'(rdValid));
    chk("rdData", e, rdData);
    #2 rdReady = 1'b0;
  endtask : getRd

  task automatic wr(input logic [17:0] a, input logic [7:0] bw,
    input logic [71:0] d, input logic [1:0] b);
    send(pbs_pkg::CMD_WRITE, a, bw, d, b);
    if (b == BK) mem[a] = merge(mem[a], d, bw);
  endtask : wr

  task automatic rd(input logic [17:0] a);
    repeat (32) @(posedge sys_clk);
    send(pbs_pkg::CMD_READ, a, 8'hff, 72'h0, BK);
    getRd(mem[a]);
  endtask : rd

  task automatic burst(input logic [17:0] a, input logic lin);
    logic [17:0] p [4];
    logic [71:0] d;
    for (int c = 0; c < 5; c++) begin
      d = {8'(c), 64'h0123_4567_89ab_cdef} ^ {54'h0, a};
      p[c % 4] = {a[17:2], lin ? a[1:0] + 2'(c) : a[1:0] ^ 2'(c)};
      send(c == 0 ? pbs_pkg::CMD_WRITE : pbs_pkg::CMD_CONTINUE, a, 8'h00,
        d, BK);
      mem[p[c % 4]] = d;
    end
    for (int c = 0; c < 4; c++) rd(p[c]);
    // Read bursts are two words long, as the controller refuses a third
    // read in flight and a refused continue would break the burst.
    fork
      for (int c = 0; c < 4; c++) send(c % 2 == 0 ? pbs_pkg::CMD_READ :
        pbs_pkg::CMD_CONTINUE, p[c & 2], 8'hff, 72'h0, BK);
      for (int c = 0; c < 4; c++) getRd(mem[p[c]]);
    join
    $display("test burst order %0d done", lin);
  endtask : burst

  initial begin
    resetn = 1'b0;
    polaritySelA = 1'b1;
    polaritySelB = 1'b0;
    orderLinear = 1'b0;
    cmdValid = 1'b0;
    cmdKind = pbs_pkg::CMD_DESELECT;
    cmdBank = 2'h0;
    cmdAddr = 18'h0;
    cmdByteWriteN = 8'hff;
    cmdWdata = 72'h0;
    rdReady = 1'b0;
    rst(1'b0);
    send(pbs_pkg::CMD_DESELECT, 18'h0, 8'hff, 72'h0, BK);
    wr(18'h00100, 8'h00, {8{9'h1a5}}, BK);
    rd(18'h00100);
    wr(18'h3ff40, 8'h00, {8{9'h0f0}}, BK);
    wr(18'h3ff40, 8'h7e, {8{9'h10f}}, BK);
    wr(18'h3ff40, 8'hff, {8{9'h155}}, BK);
    wr(18'h3ff40, 8'h00, {8{9'h0aa}}, 2'h1);
    wr(18'h3ff40, 8'h00, {8{9'h033}}, 2'h0);
    rd(18'h3ff40);
    $display("test lanes and banks done");
    burst(18'h00202, 1'b0);
    rst(1'b1);
    burst(18'h00303, 1'b1);
    send(pbs_pkg::CMD_READ, 18'h00100, 8'hff, 72'h0, BK);
    send(pbs_pkg::CMD_READ, 18'h3ff40, 8'hff, 72'h0, BK);
    repeat (60) @(posedge sys_clk);
    getRd(mem[18'h00100]);
    getRd(mem[18'h3ff40]);
    $display("test stalled reads done");
    test_done();
  end
endmodule : pipelined_burst_sram_port_test
